// ===== bench/ats_chk.sv
`timescale 1ns/100ps
module ats_chk #(
  parameter int LW = 12
) (
  input wire logic          pclk,         // acquisition clock
  input wire logic          presetn,      // async reset, low
  input wire logic          psel,         // apb select
  input wire logic          penable,      // apb access phase
  input wire logic          pwrite,       // apb direction
  input wire logic [7:0]    paddr,        // apb byte address
  input wire logic          main_trig,    // comparator main trigger
  input wire logic          dly_trig,     // comparator delayed trigger
  input wire logic          arm_led,      // pretrigger fill light
  input wire logic          ready_led,    // ready light
  input wire logic          trigd_led,    // triggered light
  input wire logic          fill_pre,     // memory: fill pretrigger
  input wire logic          fill_post,    // memory: fill posttrigger
  input wire logic          fill_dpost,   // memory: fill delayed post
  input wire logic [LW-1:0] thresh_level, // logic/pulse threshold
  input wire logic [LW-1:0] dly_level,    // delayed trigger level
  input wire logic [1:0]    trig_type     // selected trigger type
);
  // **********
  // sequencer and level checks
  // **********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_dly = psel && penable && pwrite && paddr == ats_pkg::OFS_DLY_LVL;
  sequence s_post;
    fill_post && trigd_led && !ready_led;
  endsequence
  sequence s_dwait;
    ready_led && trigd_led;
  endsequence
  a_arm_fill: assert property (arm_led == fill_pre)
    else $error("arm light and pretrigger fill disagree");
  a_ready_idle: assert property (ready_led |-> !arm_led && !fill_pre && !fill_post)
    else $error("ready light while filling");
  a_trig_post: assert property (ready_led && !trigd_led && main_trig |=> s_post)
    else $error("trigger in ready did not start posttrigger fill");
  a_post_lit: assert property (fill_post |-> trigd_led && !ready_led)
    else $error("posttrigger fill without triggered light");
  a_dwait_pair: assert property (s_post ##1 ready_led |-> s_dwait)
    else $error("delayed wait without both lights");
  a_dly_fill: assert property (s_dwait ##0 dly_trig |=> fill_dpost && !ready_led)
    else $error("delayed trigger did not start delayed fill");
  a_stop_dark: assert property (!arm_led && !ready_led && !trigd_led |->
    !fill_pre && !fill_post && !fill_dpost)
    else $error("filling while all lights dark");
  a_dly_hold: assert property ($changed(dly_level) |-> $past(wr_dly) || $past(wr_dly, 2))
    else $error("delayed level moved without its own write");
  a_edge_thr: assert property (trig_type == 2'b00 && $past(trig_type) == 2'b00 &&
    $past(trig_type, 2) == 2'b00 |-> $stable(thresh_level))
    else $error("threshold moved in edge type");
endmodule
bind ats_core ats_chk #(.LW(LW)) ats_chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .main_trig, .dly_trig, .arm_led, .ready_led, .trigd_led, .fill_pre, .fill_post,
  .fill_dpost, .thresh_level, .dly_level, .trig_type);

// ===== bench/ats_partner.sv
`timescale 1ns/100ps
module ats_partner (
  input  wire logic pclk,       // acquisition clock
  input  wire logic presetn,    // async reset, low
  input  wire logic fill_pre,   // memory filling pretrigger
  input  wire logic fill_post,  // memory filling posttrigger
  input  wire logic fill_dpost, // memory filling delayed post
  output logic      pre_done,   // pretrigger full, holdoff over
  output logic      post_done   // record complete
);
  // done waits for a count of 16, but a fill's first cycle sees the old count, so pretrigger after a finished record lasts one cycle
  logic [2:0] fill_q;
  logic [5:0] cnt_q;
  wire  [2:0] fill = {fill_dpost, fill_post, fill_pre};
  wire        full = cnt_q >= 6'h10;
  assign pre_done  = fill_pre && full;
  assign post_done = (fill_post || fill_dpost) && full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 3'h0;
      cnt_q  <= 6'h00;
    end else begin
      fill_q <= fill;
      cnt_q  <= (fill != fill_q) ? 6'h00 : cnt_q + 6'h01;
    end
  end
endmodule

// ===== bench/test_acquisition_trigger_sequencer.sv
`timescale 1ns/100ps
module test_acquisition_trigger_sequencer;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0]  btn = 5'h00;
  logic        mtrig = 1'b0;
  logic        dtrig = 1'b0;
  logic [11:0] ppos = 12'h000;
  logic [11:0] pneg = 12'h000;
  logic [31:0] prdata, rd, seed = 32'd96915;
  logic [11:0] trig_level, thresh_level, dly_level;
  logic [1:0]  trig_type, trig_source;
  logic        pready, pslverr, serr, irq, pre_done, post_done;
  logic        arm_led, ready_led, trigd_led, fill_pre, fill_post, fill_dpost;
  int          err_total = 0;
  int          checked = 0;
  int          rdy_cnt = 0;
  logic [7:0]  ra [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
  logic [31:0] rv [6] = '{32'h0, 32'h800, 32'h800, 32'h0, 32'h0, 32'h0};
  always #2.5 pclk = ~pclk;
  ats_core #(.LW(12)) ats_core_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .force_btn(btn[0]), .run_btn(btn[1]), .midpoint_level_request(btn[2]),
    .knob_up(btn[3]), .knob_dn(btn[4]), .main_trig(mtrig), .dly_trig(dtrig),
    .peak_pos(ppos), .peak_neg(pneg), .pre_done, .post_done, .arm_led, .ready_led,
    .trigd_led, .fill_pre, .fill_post, .fill_dpost, .trig_level, .thresh_level,
    .dly_level, .trig_type, .trig_source, .irq
  );
  ats_partner ats_partner_i (.pclk, .presetn, .fill_pre, .fill_post, .fill_dpost,
    .pre_done, .post_done);
  // **********
  // helpers
  // **********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] mid(logic [11:0] p, logic [11:0] n);
    logic [12:0] s;
    s = {1'b0, p} + {1'b0, n};
    return s[12:1];
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      err_total++;
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_led(logic [2:0] e);
    for (int n = 0; n < 300 && {arm_led, ready_led, trigd_led} !== e; n++) begin
      @(posedge pclk);
      if (ready_led === 1'b1 && trigd_led === 1'b0) rdy_cnt++;
    end
    chk(32'({arm_led, ready_led, trigd_led}), 32'(e));
  endtask
  // pins pass a synchroniser, so each press is held well past its latency
  task automatic press(int i);
    btn[i] <= 1'b1;
    repeat (8) @(posedge pclk);
    btn[i] <= 1'b0;
  endtask
  task automatic stop_test();
    $display("TB: errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    stop_test();
  end
  initial begin
    logic [31:0] r;
    logic [11:0] m, dl, e;
    logic [7:0]  c;
    int          j;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
      chk(32'(serr), 32'(i == 5));
    end
    press(0);
    apb(1'b0, ats_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'hFF, 32'h0);
    apb(1'b1, ats_pkg::OFS_INT_MASK, 32'h7);
    apb(1'b1, ats_pkg::OFS_CTRL, 32'h01);
    wait_led(3'b100);
    wait_led(3'b010);
    mtrig <= 1'b1;
    wait_led(3'b001);
    mtrig <= 1'b0;
    chk(32'(fill_post), 32'h1);
    wait_led(3'b100);
    chk(32'(irq), 32'h1);
    apb(1'b1, ats_pkg::OFS_INT_STAT, 32'h7);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, ats_pkg::OFS_INT_MASK, 32'h0);
    wait_led(3'b010);
    press(0);
    wait_led(3'b001);
    chk(32'(irq), 32'h0);
    apb(1'b1, ats_pkg::OFS_INT_MASK, 32'h7);
    @(posedge pclk);
    chk(32'(irq), 32'h1);
    wait_led(3'b100);
    rdy_cnt = 0;
    press(0);
    wait_led(3'b001);
    chk(32'(rdy_cnt), 32'h0);
    wait_led(3'b100);
    wait_led(3'b010);
    apb(1'b1, ats_pkg::OFS_CMD, 32'h1);
    wait_led(3'b001);
    wait_led(3'b100);
    apb(1'b1, ats_pkg::OFS_CTRL, 32'h05);
    wait_led(3'b010);
    mtrig <= 1'b1;
    wait_led(3'b011);
    mtrig <= 1'b0;
    dtrig <= 1'b1;
    wait_led(3'b001);
    chk(32'(fill_dpost), 32'h1);
    dtrig <= 1'b0;
    apb(1'b1, ats_pkg::OFS_CTRL, 32'h02);
    wait_led(3'b000);
    mtrig <= 1'b1;
    press(1);
    wait_led(3'b001);
    wait_led(3'b000);
    mtrig <= 1'b0;
    apb(1'b0, ats_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'hFF, 32'h0);
    apb(1'b0, ats_pkg::OFS_INT_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      c = {r[1:0], i == 3, (i > 1) ? 2'b10 : 2'(i), 3'b000};
      m = (i == 3) ? 12'h000 : r[13:2];
      dl = r[25:14];
      r = rnd();
      ppos <= (i == 0) ? 12'hFFF : r[11:0];
      pneg <= (i == 0) ? 12'hFFF : r[23:12];
      apb(1'b1, ats_pkg::OFS_CTRL, {24'h0, c});
      apb(1'b1, ats_pkg::OFS_MAIN_LVL, {20'h0, m});
      apb(1'b1, ats_pkg::OFS_DLY_LVL, {20'h0, dl});
      if (i == 0)
        apb(1'b1, ats_pkg::OFS_CMD, 32'h2);
      else
        press(2);
      e = (i == 1 || i == 3) ? m : mid(ppos, pneg);
      apb(1'b0, ats_pkg::OFS_MAIN_LVL, 32'h0);
      chk(rd, {20'h0, e});
      chk(32'((i == 0) ? trig_level : thresh_level), 32'(e));
      chk(32'(dly_level), 32'(dl));
      chk(32'({trig_source, trig_type}), 32'({c[7:6], c[4:3]}));
      for (int k = 0; k < 2; k++) begin
        j = ((k == 0) == (i == 3)) ? 4 : 3;
        press(j);
        if (j == 3)
          e = (e == 12'hFFF) ? e : e + 12'h001;
        else
          e = (e == 12'h000) ? e : e - 12'h001;
        chk(32'((i == 0) ? trig_level : thresh_level), 32'(e));
      end
    end
    stop_test();
  end
endmodule

// ===== design/ats_core.sv
`timescale 1ns/100ps
package ats_pkg;
  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_MAIN_LVL = 8'h08;
  localparam logic [7:0] OFS_DLY_LVL  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  // ***************************************************
  // field positions
  // ***************************************************
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_SINGLE = 1;
  localparam int CTRL_DLY_EN = 2;
  localparam int CTRL_TYPE   = 3;   // two bits
  localparam int CTRL_SHORT  = 5;
  localparam int CTRL_SRC    = 6;   // two bits
  localparam int CMD_FORCE   = 0;
  localparam int CMD_MID     = 1;
  localparam int INT_TRIG    = 0;
  localparam int INT_DONE    = 1;
  localparam int INT_STOP    = 2;
  localparam int INT_W       = 3;
  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [11:0] RST_LEVEL = 12'h800;
  localparam logic [2:0]  RST_MASK  = 3'h0;
  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [1:0] {
    TT_EDGE  = 2'b00,
    TT_LOGIC = 2'b01,
    TT_PULSE = 2'b10
  } ats_type_t;
  typedef enum logic [2:0] {
    ST_STOP  = 3'b000,
    ST_PRE   = 3'b001,
    ST_READY = 3'b010,
    ST_POST  = 3'b011,
    ST_DWAIT = 3'b100,
    ST_DPOST = 3'b101
  } ats_state_t;
endpackage

module ats_core #(
  parameter int LW = 12
) (
  input  wire logic          pclk,         // acquisition clock, 200 MHz
  input  wire logic          presetn,      // async reset, low
  input  wire logic          psel,         // apb select
  input  wire logic          penable,      // apb access phase
  input  wire logic          pwrite,       // apb direction
  input  wire logic [7:0]    paddr,        // apb byte address
  input  wire logic [31:0]   pwdata,       // apb write data
  output logic      [31:0]   prdata,       // apb read data
  output logic               pready,       // apb ready
  output logic               pslverr,      // apb error, unmapped
  input  wire logic          force_btn,    // forced-acquire pin
  input  wire logic          run_btn,      // run/halt pin
  input  wire logic          midpoint_level_request, // midpoint pin
  input  wire logic          knob_up,      // level knob step up pin
  input  wire logic          knob_dn,      // level knob step down pin
  input  wire logic          main_trig,    // comparator main trigger
  input  wire logic          dly_trig,     // comparator delayed trigger
  input  wire logic [LW-1:0] peak_pos,     // source positive peak
  input  wire logic [LW-1:0] peak_neg,     // source negative peak
  input  wire logic          pre_done,     // pretrigger filled, holdoff over
  input  wire logic          post_done,    // posttrigger fill complete
  output logic               arm_led,      // pretrigger fill light
  output logic               ready_led,    // ready light
  output logic               trigd_led,    // triggered light
  output logic               fill_pre,     // memory: fill pretrigger
  output logic               fill_post,    // memory: fill posttrigger
  output logic               fill_dpost,   // memory: fill delayed post
  output logic [LW-1:0]      trig_level,   // edge level
  output logic [LW-1:0]      thresh_level, // logic/pulse threshold
  output logic [LW-1:0]      dly_level,    // delayed trigger level
  output logic [1:0]         trig_type,    // selected trigger type
  output logic [1:0]         trig_source,  // selected source channel
  output logic               irq           // interrupt, high level
);
  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [4:0] pins_s;
  logic [4:0] pins_q;
  ats_sync #(.W(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({knob_dn, knob_up, midpoint_level_request, run_btn, force_btn}),
    .dout    (pins_s)
  );
  // previous synchronised level, so each press acts once on its rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pins_q <= 5'h00;
    else          pins_q <= pins_s;
  end
  wire [4:0] pin_rise = pins_s & ~pins_q;
  wire       force_p  = pin_rise[0];
  wire       run_p    = pin_rise[1];
  wire       mid_p    = pin_rise[2];
  wire       up_p     = pin_rise[3];
  wire       dn_p     = pin_rise[4];

  // ***************************************************
  // apb decode
  // ***************************************************
  wire wr_en     = psel & penable & pwrite;
  wire rd_setup  = psel & ~penable & ~pwrite;
  wire hit_ctrl  = paddr == ats_pkg::OFS_CTRL;
  wire hit_cmd   = paddr == ats_pkg::OFS_CMD;
  wire hit_main  = paddr == ats_pkg::OFS_MAIN_LVL;
  wire hit_dly   = paddr == ats_pkg::OFS_DLY_LVL;
  wire hit_stat  = paddr == ats_pkg::OFS_STATUS;
  wire hit_istat = paddr == ats_pkg::OFS_INT_STAT;
  wire hit_imask = paddr == ats_pkg::OFS_INT_MASK;
  wire mapped    = hit_ctrl | hit_cmd | hit_main | hit_dly | hit_stat | hit_istat | hit_imask;
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ***************************************************
  // control registers
  // ***************************************************
  logic [7:0]    ctrl_q;
  logic          run_q;
  logic [LW-1:0] main_lvl_q;
  logic [LW-1:0] dly_lvl_q;
  logic [2:0]    imask_q;
  logic [2:0]    istat_q;
  logic          force_q;
  ats_pkg::ats_state_t state_q, state_d;

  wire single_m  = ctrl_q[ats_pkg::CTRL_SINGLE];
  wire dly_en    = ctrl_q[ats_pkg::CTRL_DLY_EN];
  wire [1:0] typ = ctrl_q[ats_pkg::CTRL_TYPE +: 2];
  wire short_cls = ctrl_q[ats_pkg::CTRL_SHORT];
  wire stopped   = state_q == ats_pkg::ST_STOP;

  wire sw_force  = wr_en & hit_cmd & pwdata[ats_pkg::CMD_FORCE];
  wire sw_mid    = wr_en & hit_cmd & pwdata[ats_pkg::CMD_MID];
  wire mid_ok    = (typ == ats_pkg::TT_EDGE) | ((typ == ats_pkg::TT_PULSE) & ~short_cls);
  wire mid_go    = (mid_p | sw_mid) & mid_ok;

  // halfway between peaks; one extra bit keeps the sum from wrapping
  wire [LW:0]    peak_sum = {1'b0, peak_pos} + {1'b0, peak_neg};
  wire [LW-1:0]  mid_lvl  = peak_sum[LW:1];
  wire [LW-1:0]  lvl_max  = {LW{1'b1}};
  wire [LW-1:0]  lvl_up   = (main_lvl_q == lvl_max) ? main_lvl_q : main_lvl_q + 1'b1;
  wire [LW-1:0]  lvl_dn   = (main_lvl_q == '0) ? main_lvl_q : main_lvl_q - 1'b1;

  // knob steps take effect at once, regardless of state or mode
  // later lines win: knob over midpoint over bus write
  logic [LW-1:0] main_lvl_d;
  always_comb begin
    main_lvl_d = main_lvl_q;
    if (wr_en & hit_main) main_lvl_d = pwdata[LW-1:0];
    if (mid_go)           main_lvl_d = mid_lvl;
    if (up_p & ~dn_p)     main_lvl_d = lvl_up;
    if (dn_p & ~up_p)     main_lvl_d = lvl_dn;
  end

  // ***************************************************
  // trigger sequencer
  // ***************************************************
  wire force_now = force_q | force_p | sw_force;
  // in delayed mode only the delayed fill closes a record
  wire seq_done  = (state_q == ats_pkg::ST_POST  & post_done & ~dly_en) |
                   (state_q == ats_pkg::ST_DPOST & post_done);
  wire ev_trig   = (state_q == ats_pkg::ST_READY) & (main_trig | force_now);
  wire ev_stop   = seq_done & single_m;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ats_pkg::ST_STOP: begin
        if (run_q) state_d = ats_pkg::ST_PRE;
      end
      ats_pkg::ST_PRE: begin
        // a latched force waits out holdoff, then skips the trigger wait
        if (pre_done) state_d = force_now ? ats_pkg::ST_POST : ats_pkg::ST_READY;
      end
      ats_pkg::ST_READY: begin
        if (main_trig | force_now) state_d = ats_pkg::ST_POST;
      end
      ats_pkg::ST_POST: begin
        if (dly_en)         state_d = ats_pkg::ST_DWAIT;
        else if (post_done) state_d = single_m ? ats_pkg::ST_STOP : ats_pkg::ST_PRE;
      end
      ats_pkg::ST_DWAIT: begin
        if (dly_trig | force_now) state_d = ats_pkg::ST_DPOST;
      end
      ats_pkg::ST_DPOST: begin
        if (post_done) state_d = single_m ? ats_pkg::ST_STOP : ats_pkg::ST_PRE;
      end
      default: state_d = ats_pkg::ST_STOP;
    endcase
    if (!run_q) state_d = ats_pkg::ST_STOP;
  end

  // force is consumed when it moves the sequence on
  wire force_used = force_now &
                    ((state_q == ats_pkg::ST_PRE & pre_done) |
                     state_q == ats_pkg::ST_READY | state_q == ats_pkg::ST_DWAIT);
  // a press while stopped is dropped, not held for the next run
  wire force_d    = stopped ? 1'b0 : ((force_q | force_p | sw_force) & ~force_used);

  // run cleared by hardware once a single sequence finishes
  logic run_d;
  always_comb begin
    run_d = run_q;
    if (ev_stop) run_d = 1'b0;
    if (run_p)   run_d = ~run_q;
    if (wr_en & hit_ctrl) run_d = pwdata[ats_pkg::CTRL_RUN];
  end

  // ***************************************************
  // interrupts
  // ***************************************************
  wire [2:0] ev_vec  = {ev_stop, seq_done, ev_trig};
  wire [2:0] w1c     = (wr_en & hit_istat) ? pwdata[2:0] : 3'h0;
  wire [2:0] istat_d = (istat_q & ~w1c) | ev_vec;  // a new event beats its own clear
  assign irq = |(istat_q & imask_q);

  // ***************************************************
  // state registers
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= ats_pkg::RST_CTRL;
      run_q      <= 1'b0;
      main_lvl_q <= ats_pkg::RST_LEVEL;
      dly_lvl_q  <= ats_pkg::RST_LEVEL;
      imask_q    <= ats_pkg::RST_MASK;
      istat_q    <= 3'h0;
      force_q    <= 1'b0;
      state_q    <= ats_pkg::ST_STOP;
    end else begin
      if (wr_en & hit_ctrl)  ctrl_q  <= pwdata[7:0];
      if (wr_en & hit_dly)   dly_lvl_q <= pwdata[LW-1:0];
      if (wr_en & hit_imask) imask_q <= pwdata[2:0];
      run_q      <= run_d;
      main_lvl_q <= main_lvl_d;
      istat_q    <= istat_d;
      force_q    <= force_d;
      state_q    <= state_d;
    end
  end

  // ***************************************************
  // indicators and memory strobes
  // ***************************************************
  wire arm_d   = state_d == ats_pkg::ST_PRE;
  wire ready_d = state_d == ats_pkg::ST_READY | state_d == ats_pkg::ST_DWAIT;
  wire trigd_d = state_d == ats_pkg::ST_POST | state_d == ats_pkg::ST_DWAIT |
                 state_d == ats_pkg::ST_DPOST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_led    <= 1'b0;
      ready_led  <= 1'b0;
      trigd_led  <= 1'b0;
      fill_pre   <= 1'b0;
      fill_post  <= 1'b0;
      fill_dpost <= 1'b0;
    end else begin
      arm_led    <= arm_d;
      ready_led  <= ready_d;
      trigd_led  <= trigd_d;
      // no pretrigger writes once the trigger wait begins, so arm and fill agree
      fill_pre   <= arm_d;
      fill_post  <= state_d == ats_pkg::ST_POST;
      fill_dpost <= state_d == ats_pkg::ST_DPOST;
    end
  end

  // ***************************************************
  // level and type outputs
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_level   <= ats_pkg::RST_LEVEL;
      thresh_level <= ats_pkg::RST_LEVEL;
      dly_level    <= ats_pkg::RST_LEVEL;
      trig_type    <= 2'h0;
      trig_source  <= 2'h0;
    end else begin
      // the one level control serves as level or threshold by type
      if (typ == ats_pkg::TT_EDGE) trig_level   <= main_lvl_d;
      else                         thresh_level <= main_lvl_d;
      dly_level    <= dly_lvl_q;
      trig_type    <= typ;
      // source follows only its own field; channel display has no say
      trig_source  <= ctrl_q[ats_pkg::CTRL_SRC +: 2];
    end
  end

  // ***************************************************
  // read data, captured in the setup phase
  // ***************************************************
  wire [31:0] stat_word = {24'h000000, run_q, force_q, trigd_led, ready_led, arm_led,
                           state_q};
  // command and unmapped addresses read as zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_ctrl)  rd_mux = {24'h000000, ctrl_q[7:1], run_q};
    if (hit_main)  rd_mux = {{(32-LW){1'b0}}, main_lvl_q};
    if (hit_dly)   rd_mux = {{(32-LW){1'b0}}, dly_lvl_q};
    if (hit_stat)  rd_mux = stat_word;
    if (hit_istat) rd_mux = {29'h00000000, istat_q};
    if (hit_imask) rd_mux = {29'h00000000, imask_q};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)      prdata <= 32'h00000000;
    else if (rd_setup) prdata <= rd_mux;
  end
endmodule

// ===== design/ats_sync.sv
`timescale 1ns/100ps
module ats_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // acquisition clock
  input  wire logic         presetn, // async reset, low
  input  wire logic [W-1:0] din,     // asynchronous pins
  output logic      [W-1:0] dout     // filtered, synchronous level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // ***************************************************
  // three stages; a change is taken once stages two and three agree
  // ***************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) dout[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule
